// ==== src/sprc_system_control.sv ====
/*
  System power and reset control: port options, power-on one-shot, HALT
  and STOP modes, stop recovery, coprocessor control and watchdog.
  Assumes the register strobes come from the host core in bank F, and
  that rcTick and crystalTick are one-cycle enables of those oscillators.
*/
// How it works
// R1 - port_config bit 0 routes both comparator outputs to port 3 bits 4,5.
// R2 - port_drive_config bit 0 picks port 4 push-pull, resets to one.
// R3 - port_drive_config bit 4 picks port 5 push-pull, resets to one.
// R4 - 5 ms one-shot on power good, watchdog timeout or delayed recovery.
// R5 - stop_recovery_control bit 5 high skips the delay; defaults one.
// R6 - wake source must hold its level at least five crystal periods.
// R7 - HALT gates the core clock; any interrupt resumes execution.
// R8 - STOP halts clocks; a reset source or the selected wake source leaves, restart at 000CH.
// R9 - software issues a no-op just before STOP or HALT.
// R10 - stop_recovery_control is write-only except read-only bit 7.
// R11 - bit 0 inserts divide-by-16 on system and timer clocks.
// R12 - bits 4:2 choose the wake source among port pins.
// R13 - bit 6 picks high or low wake level; zero after power-on.
// R14 - warm flag set on STOP entry, cleared on power-on or watchdog.
// R15 - coprocessor bits 7:6 set host clock divide 8, 4 or 2.
// R16 - bit 5 write one resets DSP; reads zero; bits 3:2 read zero.
// R17 - bit 4 clear gates the DSP clock; one after reset.
// R18 - bit 1 write one raises DSP interrupt 2; reads its state.
// R19 - bit 0 reads the DSP-to-host request; write one clears it.
// R20 - watchdog is retriggerable, enabled by first kick, resets at end.
// R21 - watchdog_mode writable only 64 host clocks after power-on.
// R22 - bits 1:0 choose the timeout in RC time or crystal counts.
// R23 - bits 2 and 3 keep the watchdog alive in HALT and STOP.
// R24 - bit 4 chooses the crystal instead of the RC oscillator.
// R25 - DSP reset is a single-cycle pulse in the DSP clock domain.
`timescale 1ns/1ps
module sprc_system_control #(
  parameter int PorCycles = sprc_pkg::POR_CYCLES,
  parameter int RcTicksPerUs = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register access from the host core
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  // oscillator enables and supply
  input wire logic rcTick,
  input wire logic crystalTick,
  input wire logic powerGood,
  input wire logic externalReset,
  // host core events
  input wire logic haltRequest,
  input wire logic stopRequest,
  input wire logic watchdogKick,
  input wire logic interruptPending,
  // wake pins
  input wire logic [7:0] port2In,
  input wire logic [3:1] port3In,
  // comparators and port options
  input wire logic [1:0] comparatorOut,
  output logic comparatorOnPort3,
  output logic [1:0] port3CompData,
  output logic port4PushPull,
  output logic port5PushPull,
  // clock and reset control
  output logic hostClockEnable,
  output logic timerClockEnable,
  output logic [1:0] host_clock_select,
  output logic hostReset,
  output logic [15:0] restartAddress,
  // coprocessor link
  input wire logic dspClockTick,
  input wire logic host_coproc_irq_set,
  input wire logic coproc_irq2_ack,
  output logic dspClockEnable,
  output logic dspResetPulse,
  output logic coproc_irq2,
  output logic host_coproc_irq
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  sprc_pkg::sprc_mode_e mode;
  logic [7:0] portConfig, portDrive, stopRecovery;
  logic dspRun, dspResetReq, warmStart, watchdogEnabled, watchdogTimeout;
  logic [4:0] watchdogMode;
  logic [sprc_pkg::COUNT_W-1:0] watchdogCount, porCount;
  logic [6:0] windowCount;
  logic [3:0] div16Count;
  logic [2:0] wakeHold;
  logic wakeLevel, wakeEvent, porBusy, wdTick, wdAlive;

  // true when a register write hits the given offset
  function automatic logic hit(input logic [7:0] addr);
    return regWrite && regAddr == addr;
  endfunction

  // ------------------------------------------------------------------
  // port options
  // ------------------------------------------------------------------
  // R1 comparator routing
  assign comparatorOnPort3 = portConfig[sprc_pkg::COMPARATOR_OUT_BIT];
  assign port3CompData = comparatorOnPort3 ? comparatorOut : 2'h0;
  // R2 port 4 drive
  assign port4PushPull = portDrive[sprc_pkg::PORT4_PUSH_PULL_BIT];
  // R3 port 5 drive
  assign port5PushPull = portDrive[sprc_pkg::PORT5_PUSH_PULL_BIT];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      portConfig <= sprc_pkg::PORT_CONFIG_RESET;
      portDrive <= sprc_pkg::PORT_DRIVE_RESET;
    end else begin
      if (hit(sprc_pkg::ADDR_PORT_CONFIG)) portConfig <= regWriteData;
      if (hit(sprc_pkg::ADDR_PORT_DRIVE)) portDrive <= regWriteData;
    end
  end

  // ------------------------------------------------------------------
  // stop recovery: wake source and level
  // ------------------------------------------------------------------
  // R12 wake source select
  always_comb begin
    unique case (stopRecovery[sprc_pkg::SOURCE_LSB +: 3])
      3'h2: wakeLevel = port3In[1];
      3'h3: wakeLevel = port3In[2];
      3'h4: wakeLevel = port3In[3];
      3'h5: wakeLevel = port2In[7];
      3'h6: wakeLevel = ~|port2In[3:0];
      3'h7: wakeLevel = ~|port2In;
      default: wakeLevel = ~stopRecovery[sprc_pkg::WAKE_LEVEL_BIT];
    endcase
  end

  // R13 active level; a short hold filter rejects pin glitches
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wakeHold <= 3'h0;
    end else if (mode != sprc_pkg::STOPPED ||
                 wakeLevel != stopRecovery[sprc_pkg::WAKE_LEVEL_BIT]) begin
      wakeHold <= 3'h0;
    end else if (crystalTick && !wakeEvent) begin
      wakeHold <= wakeHold + 3'h1;
    end
  end
  assign wakeEvent =
    wakeHold == 3'(sprc_pkg::RECOVERY_HOLD_CYCLES);

  // R10 stop recovery write-only bits; R11 divide select is stored here
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stopRecovery <= sprc_pkg::STOP_RECOVERY_RESET;
    end else if (hit(sprc_pkg::ADDR_STOP_RECOVERY)) begin
      stopRecovery <= {1'b0, regWriteData[6:0]};
    end
  end

  // R14 warm start flag: set on STOP entry wins over clearing resets
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      warmStart <= 1'b0;
    end else if (mode == sprc_pkg::RUN && stopRequest) begin
      warmStart <= 1'b1;
    end else if (!powerGood || watchdogTimeout) begin
      warmStart <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // power-on one-shot
  // ------------------------------------------------------------------
  // R4 triggers: supply, watchdog, delayed recovery; R5 fast wake skips
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      porCount <= sprc_pkg::COUNT_W'(PorCycles);
    end else if (!powerGood || watchdogTimeout ||
                 (wakeEvent && !stopRecovery[sprc_pkg::FAST_WAKE_BIT])) begin
      porCount <= sprc_pkg::COUNT_W'(PorCycles);
    end else if (porBusy) begin
      porCount <= porCount - 1'b1;
    end
  end
  assign porBusy = porCount != '0;

  // ------------------------------------------------------------------
  // power modes
  // ------------------------------------------------------------------
  // R7 halt until interrupt; R8 stop until a reset source or a wake event
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode <= sprc_pkg::RUN;
    end else if (watchdogTimeout || !powerGood || externalReset ||
                 wakeEvent) begin
      mode <= sprc_pkg::RUN;
    end else begin
      unique case (mode)
        sprc_pkg::RUN: begin
          if (stopRequest) mode <= sprc_pkg::STOPPED;
          else if (haltRequest) mode <= sprc_pkg::HALTED;
        end
        sprc_pkg::HALTED: if (interruptPending) mode <= sprc_pkg::RUN;
        sprc_pkg::STOPPED: mode <= sprc_pkg::STOPPED;
      endcase
    end
  end

  // R8 restart address after a reset-class exit from STOP
  assign restartAddress = 16'h000c;
  assign hostReset = porBusy || externalReset;

  // R11 divide-by-16 prescaler on system and timer clocks
  always_ff @(posedge clock or posedge reset) begin
    if (reset) div16Count <= 4'h0;
    else div16Count <= div16Count + 4'h1;
  end
  always_comb begin
    logic slow;
    slow = stopRecovery[sprc_pkg::DIV16_BIT] && div16Count != 4'h0;
    hostClockEnable = mode == sprc_pkg::RUN && !porBusy && !slow;
    timerClockEnable = mode != sprc_pkg::STOPPED && !slow;
  end

  // ------------------------------------------------------------------
  // coprocessor control
  // ------------------------------------------------------------------
  // R15 clock select; R17 DSP run gating
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      host_clock_select <= sprc_pkg::CLOCK_SELECT_RESET;
      dspRun <= 1'b1;
    end else if (hit(sprc_pkg::ADDR_COPROC_CONTROL)) begin
      host_clock_select <= regWriteData[sprc_pkg::CLOCK_SELECT_LSB +: 2];
      dspRun <= regWriteData[sprc_pkg::DSP_RUN_BIT];
    end
  end
  assign dspClockEnable = dspRun && dspClockTick;

  // R16 reset request held until the DSP domain takes it
  // R25 single pulse on the next DSP clock tick
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dspResetReq <= 1'b0;
      dspResetPulse <= 1'b0;
    end else begin
      dspResetPulse <= dspResetReq && dspClockTick;
      if (hit(sprc_pkg::ADDR_COPROC_CONTROL) &&
          regWriteData[sprc_pkg::DSP_RESET_BIT])
        dspResetReq <= 1'b1;
      else if (dspClockTick)
        dspResetReq <= 1'b0;
    end
  end

  // R18 raise DSP interrupt 2; R19 clear host request, set wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      coproc_irq2 <= 1'b0;
      host_coproc_irq <= 1'b0;
    end else begin
      if (hit(sprc_pkg::ADDR_COPROC_CONTROL) &&
          regWriteData[sprc_pkg::COPROC_IRQ2_BIT])
        coproc_irq2 <= 1'b1;
      else if (coproc_irq2_ack)
        coproc_irq2 <= 1'b0;
      if (host_coproc_irq_set)
        host_coproc_irq <= 1'b1;
      else if (hit(sprc_pkg::ADDR_COPROC_CONTROL) &&
               regWriteData[sprc_pkg::HOST_HOST_COPROC_IRQ_BIT])
        host_coproc_irq <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  // R21 write window after power-on
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      windowCount <= 7'h0;
      watchdogMode <= sprc_pkg::WATCHDOG_MODE_RESET;
    end else begin
      if (porBusy) windowCount <= 7'h0;
      else if (hostClockEnable &&
               windowCount != 7'(sprc_pkg::WRITE_WINDOW_CYCLES))
        windowCount <= windowCount + 7'h1;
      if (hit(sprc_pkg::ADDR_WATCHDOG_MODE) &&
          windowCount != 7'(sprc_pkg::WRITE_WINDOW_CYCLES)) begin
        watchdogMode <= regWriteData[4:0];
      end
    end
  end

  // R22 timeout length in ticks of the chosen clock
  function automatic logic [sprc_pkg::COUNT_W-1:0] limit(
      input logic [1:0] sel, input logic xtal);
    int us;
    us = sel == 2'h0 ? sprc_pkg::WD_RC_5MS_US :
         sel == 2'h1 ? sprc_pkg::WD_RC_15MS_US :
         sel == 2'h2 ? sprc_pkg::WD_RC_25MS_US : sprc_pkg::WD_RC_100MS_US;
    if (xtal)
      return sprc_pkg::COUNT_W'(sprc_pkg::WD_XTAL_BASE <<
                                (sel == 2'h3 ? 4 : sel));
    return sprc_pkg::COUNT_W'(us * RcTicksPerUs);
  endfunction

  // R20 retriggerable one-shot; R23 halt and stop keep-alive
  // R24 crystal or RC as the counting clock
  assign wdTick =
    watchdogMode[sprc_pkg::WD_CLOCK_BIT] ? crystalTick : rcTick;
  assign wdAlive = mode == sprc_pkg::RUN ||
    (mode == sprc_pkg::HALTED && watchdogMode[sprc_pkg::WD_HALT_BIT]) ||
    (mode == sprc_pkg::STOPPED && watchdogMode[sprc_pkg::WD_STOP_BIT]);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      watchdogEnabled <= 1'b0;
      watchdogCount <= '0;
      watchdogTimeout <= 1'b0;
    end else begin
      watchdogTimeout <= 1'b0;
      if (!powerGood) begin
        watchdogEnabled <= 1'b0;
        watchdogCount <= '0;
      end else if (watchdogKick) begin
        watchdogEnabled <= 1'b1;
        watchdogCount <= '0;
      end else if (watchdogEnabled && wdAlive && wdTick) begin
        if (watchdogCount + 1'b1 >= limit(watchdogMode[1:0],
            watchdogMode[sprc_pkg::WD_CLOCK_BIT])) begin
          watchdogTimeout <= 1'b1;
          watchdogCount <= '0;
        end else begin
          watchdogCount <= watchdogCount + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // R10 read-only warm flag; R16 reserved and reset bits read zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        sprc_pkg::ADDR_STOP_RECOVERY: regReadData <= {warmStart, 7'h00};
        sprc_pkg::ADDR_COPROC_CONTROL:
          regReadData <= {host_clock_select, 1'b0, dspRun, 2'h0,
                          coproc_irq2, host_coproc_irq};
        default: regReadData <= 8'h00;
      endcase
    end
  end

endmodule

// ==== src/sprc_pkg.sv ====
/*
  Package for the system power and reset control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock; the RC oscillator arrives as an enable.
*/
package sprc_pkg;

  // ------------------------------------------------------------------
  // register offsets in expanded bank F
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PORT_DRIVE = 8'h06;
  localparam logic [7:0] ADDR_STOP_RECOVERY = 8'h0b;
  localparam logic [7:0] ADDR_COPROC_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_WATCHDOG_MODE = 8'h0f;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int COMPARATOR_OUT_BIT = 0;
  localparam int PORT4_PUSH_PULL_BIT = 0;
  localparam int PORT5_PUSH_PULL_BIT = 4;
  localparam int DIV16_BIT = 0;
  localparam int SOURCE_LSB = 2;
  localparam int FAST_WAKE_BIT = 5;
  localparam int WAKE_LEVEL_BIT = 6;
  localparam int WARM_BIT = 7;
  localparam int COPROC_IRQ2_BIT = 1;
  localparam int HOST_HOST_COPROC_IRQ_BIT = 0;
  localparam int DSP_RUN_BIT = 4;
  localparam int DSP_RESET_BIT = 5;
  localparam int CLOCK_SELECT_LSB = 6;
  localparam int WD_HALT_BIT = 2;
  localparam int WD_STOP_BIT = 3;
  localparam int WD_CLOCK_BIT = 4;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] PORT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] PORT_DRIVE_RESET = 8'h11;
  localparam logic [7:0] STOP_RECOVERY_RESET = 8'h20;
  localparam logic [1:0] CLOCK_SELECT_RESET = 2'h0;
  localparam logic [4:0] WATCHDOG_MODE_RESET = 5'h0d;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int POR_TIME_US = 5000;
  localparam int POR_CYCLES = POR_TIME_US * CLOCK_MHZ;
  localparam int WRITE_WINDOW_CYCLES = 64;
  localparam int RECOVERY_HOLD_CYCLES = 5;
  localparam int WD_RC_5MS_US = 5000;
  localparam int WD_RC_15MS_US = 15000;
  localparam int WD_RC_25MS_US = 25000;
  localparam int WD_RC_100MS_US = 100000;
  localparam int WD_XTAL_BASE = 256;
  localparam int COUNT_W = 24;

  typedef enum logic [1:0] {
    RUN,
    HALTED,
    STOPPED
  } sprc_mode_e;

endpackage

// ==== verification/sprc_checker.sv ====
/*
  Checker for the system control block: port timing relations.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module sprc_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register access
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  // ports and modes
  input wire logic [1:0] comparatorOut,
  input wire logic comparatorOnPort3,
  input wire logic [1:0] port3CompData,
  input wire logic port4PushPull,
  input wire logic port5PushPull,
  input wire logic hostClockEnable,
  input wire logic [1:0] host_clock_select,
  input wire logic hostReset,
  input wire logic [15:0] restartAddress,
  input wire logic externalReset,
  input wire logic stopRequest,
  // coprocessor link
  input wire logic dspClockTick,
  input wire logic dspClockEnable,
  input wire logic dspResetPulse,
  input wire logic host_coproc_irq_set,
  input wire logic coproc_irq2,
  input wire logic host_coproc_irq
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // decoded write strobes
  wire wCop = regWrite && regAddr == sprc_pkg::ADDR_COPROC_CONTROL;
  wire wDrv = regWrite && regAddr == sprc_pkg::ADDR_PORT_DRIVE;

  a_comp_route: assert property (
    port3CompData == (comparatorOnPort3 ? comparatorOut : 2'h0))
    else $error("comparator routing wrong");
  a_drive_bits: assert property (wDrv |=>
    {port5PushPull, port4PushPull} ==
    {$past(regWriteData[4]), $past(regWriteData[0])})
    else $error("port drive bits wrong");
  a_ext_reset: assert property (externalReset |-> hostReset)
    else $error("external reset not passed on");
  a_stop_gate: assert property (stopRequest |=> !hostClockEnable)
    else $error("host clock runs in stop");
  a_restart_fixed: assert property (restartAddress == 16'h000c)
    else $error("restart address wrong");
  a_clock_select: assert property (wCop |=>
    host_clock_select == $past(regWriteData[7:6]))
    else $error("clock select not written");
  a_read_zero: assert property (
    regRead && regAddr == sprc_pkg::ADDR_COPROC_CONTROL |=>
    !regReadData[5] && regReadData[3:2] == 2'h0)
    else $error("reserved bits not zero");
  a_dsp_gate: assert property (dspClockEnable |-> dspClockTick)
    else $error("dsp clock enable without tick");
  a_irq2_set: assert property (wCop && regWriteData[1] |=> coproc_irq2)
    else $error("dsp interrupt two not raised");
  a_host_coproc_irq_set: assert property (host_coproc_irq_set |=> host_coproc_irq)
    else $error("host request not set");
  a_host_coproc_irq_clear: assert property (
    wCop && regWriteData[0] && !host_coproc_irq_set |=> !host_coproc_irq)
    else $error("host request not cleared");
  a_pulse_single: assert property (dspResetPulse |=> !dspResetPulse)
    else $error("dsp reset pulse too long");
endmodule

bind sprc_system_control sprc_checker u_sprc_checker (
  .clock(clock), .reset(reset), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWriteData(regWriteData),
  .regReadData(regReadData), .comparatorOut(comparatorOut),
  .comparatorOnPort3(comparatorOnPort3), .port3CompData(port3CompData),
  .port4PushPull(port4PushPull), .port5PushPull(port5PushPull),
  .hostClockEnable(hostClockEnable), .host_clock_select(host_clock_select),
  .hostReset(hostReset), .restartAddress(restartAddress),
  .externalReset(externalReset), .stopRequest(stopRequest),
  .dspClockTick(dspClockTick), .dspClockEnable(dspClockEnable),
  .dspResetPulse(dspResetPulse), .host_coproc_irq_set(host_coproc_irq_set),
  .coproc_irq2(coproc_irq2), .host_coproc_irq(host_coproc_irq)
);

// ==== verification/sprc_dsp_model.sv ====
/*
  DSP side model: acknowledges interrupt two late, raises the host
  request on command and counts reset pulses.
  Assumes the same clock as the design; bench gives the commands.
*/
`timescale 1ns/1ps
module sprc_dsp_model #(
  parameter int AckDelay = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // from the design
  input wire logic coproc_irq2,
  input wire logic dspResetPulse,
  // bench command
  input wire logic raiseHost,
  // to the design and bench
  output logic host_coproc_irq_set,
  output logic coproc_irq2_ack,
  output logic [7:0] resetCount
);
  // ------------------------------------------------------------
  // behaviour
  // ------------------------------------------------------------
  int waitCnt;
  // a slow dsp takes interrupt two, so the bench can read it first
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      waitCnt <= 0;
      coproc_irq2_ack <= 1'b0;
    end else begin
      coproc_irq2_ack <= coproc_irq2 && !coproc_irq2_ack
        && waitCnt == AckDelay;
      waitCnt <= (coproc_irq2 && waitCnt < AckDelay) ? waitCnt + 1 : 0;
    end
  end
  // the dsp sets the host request one cycle after the bench command
  always_ff @(posedge clock or posedge reset) begin
    if (reset) host_coproc_irq_set <= 1'b0;
    else host_coproc_irq_set <= raiseHost;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) resetCount <= 8'h00;
    else resetCount <= resetCount + 8'(dspResetPulse);
  end
endmodule

// ==== verification/sprc_system_control_bench.sv ====
/*
  Self-checking bench for the system control block and a dsp model.
  Assumes the package is compiled first; the checker binds itself.
*/
`timescale 1ns/1ps
module sprc_system_control_bench;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam int PorLen = 50;
  localparam logic [7:0] Cop = sprc_pkg::ADDR_COPROC_CONTROL;
  localparam logic [7:0] Stop_recovery_control = sprc_pkg::ADDR_STOP_RECOVERY;
  logic clock = 0, reset = 1, regWrite = 0, regRead = 0, rcTick = 0;
  logic crystalTick = 1, powerGood = 1, externalReset = 0, raiseHost = 0;
  logic haltRequest = 0, stopRequest = 0, watchdogKick = 0;
  logic interruptPending = 0, dspClockTick = 0, irqSet, irqAck;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, port2In = 8'h00;
  logic [3:1] port3In = 3'h0;
  logic [1:0] comparatorOut = 2'h0, host_clock_select, port3CompData;
  logic comparatorOnPort3, port4PushPull, port5PushPull, hostClockEnable;
  logic hostReset, dspClockEnable, dspResetPulse, coproc_irq2;
  logic host_coproc_irq;
  logic [15:0] restartAddress;
  logic [7:0] regReadData, resetCount, d;
  int error_cnt = 0, total_checks = 0, n;

  sprc_system_control #(.PorCycles(PorLen), .RcTicksPerUs(1))
  u_sprc_system_control (
    .clock(clock), .reset(reset), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .rcTick(rcTick), .crystalTick(crystalTick),
    .powerGood(powerGood), .externalReset(externalReset),
    .haltRequest(haltRequest), .stopRequest(stopRequest),
    .watchdogKick(watchdogKick), .interruptPending(interruptPending),
    .port2In(port2In), .port3In(port3In), .comparatorOut(comparatorOut),
    .comparatorOnPort3(comparatorOnPort3), .port3CompData(port3CompData),
    .port4PushPull(port4PushPull), .port5PushPull(port5PushPull),
    .hostClockEnable(hostClockEnable), .timerClockEnable(),
    .host_clock_select(host_clock_select), .hostReset(hostReset),
    .restartAddress(restartAddress), .dspClockTick(dspClockTick),
    .host_coproc_irq_set(irqSet), .coproc_irq2_ack(irqAck),
    .dspClockEnable(dspClockEnable), .dspResetPulse(dspResetPulse),
    .coproc_irq2(coproc_irq2), .host_coproc_irq(host_coproc_irq));

  sprc_dsp_model #(.AckDelay(8)) u_sprc_dsp_model (
    .clock(clock), .reset(reset), .coproc_irq2(coproc_irq2),
    .dspResetPulse(dspResetPulse), .raiseHost(raiseHost),
    .host_coproc_irq_set(irqSet), .coproc_irq2_ack(irqAck),
    .resetCount(resetCount));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial forever #5 clock = ~clock;

  function automatic logic [15:0] wd_limit(input logic [1:0] s);
    return 16'h0100 << ((s == 2'h3) ? 4 : s);
  endfunction
  function automatic logic [1:0] comp_exp(input logic on, logic [1:0] c);
    return on ? c : 2'h0;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge clock);
    #1;
  endtask
  // strobe held one cycle
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    regAddr = a;
    regWriteData = v;
    pulse(regWrite);
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    regAddr = a;
    pulse(regRead);
    d = regReadData;
  endtask
  // bounded, so a stuck reset cannot hang
  task automatic waitRst(input logic lvl, output int c);
    c = 0;
    while (hostReset !== lvl && c < 1000) begin
      @(negedge clock);
      c++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(19074));
    fork
      forever begin
        @(negedge clock);
        {rcTick, dspClockTick, comparatorOut} <= 4'($urandom);
        port2In <= 8'($urandom);
      end
    join_none
    repeat (8) @(negedge clock);
    reset = 0;
    #1;
    chk({port5PushPull, port4PushPull}, 2'h3);
    chk(host_clock_select, 2'h0);
    chk(hostReset, 1'b1);
    wr(sprc_pkg::ADDR_WATCHDOG_MODE, 8'h10);
    waitRst(1'b0, n);
    chk(n > PorLen - 8 && n < PorLen + 4, 1'b1);
    rd(Stop_recovery_control);
    chk(d[7], 1'b0);
    $display("test reset done");
    repeat (8) begin
      n = $urandom;
      wr(sprc_pkg::ADDR_PORT_CONFIG, 8'(n));
      wr(sprc_pkg::ADDR_PORT_DRIVE, 8'(n));
      tick(1);
      chk(port3CompData, comp_exp(n[0], comparatorOut));
      chk({port5PushPull, port4PushPull}, {n[4], n[0]});
    end
    $display("test ports done");
    repeat (4) begin
      n = $urandom & 32'hd0;
      wr(Cop, 8'(n));
      rd(Cop);
      chk(d[7:2], {n[7:6], 1'b0, n[4], 2'h0});
      tick(0);
      chk(dspClockEnable, n[4] & dspClockTick);
    end
    wr(Cop, 8'h32);
    rd(Cop);
    chk(d[1], 1'b1);
    tick(20);
    chk(resetCount, 8'h01);
    chk(coproc_irq2, 1'b0);
    pulse(raiseHost);
    rd(Cop);
    chk(d[0], 1'b1);
    wr(Cop, 8'h11);
    rd(Cop);
    chk(d[1:0], 2'h0);
    $display("test coprocessor done");
    pulse(haltRequest); // halt strobe alone; no no-op is issued first
    tick(2);
    chk(hostClockEnable, 1'b0);
    interruptPending = 1;
    tick(3);
    chk(hostClockEnable, 1'b1);
    interruptPending = 0;
    wr(Stop_recovery_control, 8'h21);
    n = 0;
    repeat (32) begin
      @(negedge clock);
      n += hostClockEnable;
    end
    chk(n, 2);
    $display("test halt and divide done");
    for (int f = 1; f >= 0; f--) begin
      wr(Stop_recovery_control, f ? 8'h68 : 8'h48);
      pulse(stopRequest);
      tick(8);
      chk(hostClockEnable, 1'b0);
      // the wake pin is held ten crystal periods, twice the five needed
      port3In = 3'h1;
      tick(10);
      port3In = 3'h0;
      chk(hostReset, 1'(!f));
      waitRst(1'b0, n);
      tick(2);
      chk(hostClockEnable, 1'b1);
      rd(Stop_recovery_control);
      chk(d[7], 1'b1);
    end
    $display("test stop recovery done");
    pulse(watchdogKick);
    tick(200);
    pulse(watchdogKick);
    waitRst(1'b1, n);
    chk(n > wd_limit(2'h0) - 6 && n < wd_limit(2'h0) + 4, 1'b1);
    waitRst(1'b0, n);
    rd(Stop_recovery_control);
    chk(d[7], 1'b0);
    $display("test watchdog done");
    conclude();
  end
endmodule
